// ==== srp_profile_regs.svh ====
// Register indices, masks, reset value, bus answers and code tables of the profile bank
`ifndef SRP_PROFILE_REGS_SVH
`define SRP_PROFILE_REGS_SVH
// ==========================================================
// Register indices (byte address is four times the index)
`define SRP_IDX_WORD1 10'h094
`define SRP_IDX_WORD2 10'h096
`define SRP_IDX_WORD3 10'h098
`define SRP_IDX_WORD4 10'h09a
`define SRP_IDX_WORD5 10'h09c
`define SRP_IDX_WORD6 10'h09e
`define SRP_IDX_STATUS 10'h0a0
// ==========================================================
// Writable bit masks and reset value
`define SRP_MASK_WORD1 32'h7fffffff
`define SRP_MASK_WORD2 32'h7fffffff
`define SRP_MASK_WORD3 32'h7ffffffe
`define SRP_MASK_WORD4 32'h7fffffff
`define SRP_MASK_WORD5 32'h7ffffffe
`define SRP_MASK_WORD6 32'h7fff8000
`define SRP_RESET_VAL 32'h00000000
// ==========================================================
// Bus answers
`define SRP_RESP_OKAY 2'h0
`define SRP_RESP_SLVERR 2'h2
// ==========================================================
// Duty codes in 1/256 steps: hysteresis 0..3 percent
`define SRP_HYS_0 8'h00
`define SRP_HYS_1 8'h03
`define SRP_HYS_2 8'h06
`define SRP_HYS_3 8'h08
// Minimum start duty 1, 3, 5, 10 percent
`define SRP_MIN_0 8'h03
`define SRP_MIN_1 8'h08
`define SRP_MIN_2 8'h0d
`define SRP_MIN_3 8'h1a
// Speed pin filter band, 0.4 percent
`define SRP_FILT_BAND 9'h001
`endif

// ==== srp_profile_pkg.sv ====
// Types of the speed reference profile bank
package srp_profile_pkg;
	typedef enum logic [1:0] {
		SRP_PROF_DIRECT = 2'b00,
		SRP_PROF_LINEAR = 2'b01,
		SRP_PROF_STAIR = 2'b10,
		SRP_PROF_FWDREV = 2'b11
	} srp_prof_t;
	typedef enum logic [1:0] {
		SRP_VM_NONE = 2'b00,
		SRP_VM_ABOVE = 2'b01,
		SRP_VM_BELOW = 2'b10,
		SRP_VM_NA = 2'b11
	} srp_vmode_t;
	typedef struct packed {
		srp_prof_t profile;
		logic [7:0] turn_on_duty_set1;
		logic [7:0] turn_off_duty_set1;
		logic [7:0] clamp_duty_set1;
		logic [7:0] duty_a;
		logic [7:0] duty_b;
		logic [7:0] duty_c;
		logic [7:0] duty_d;
		logic [7:0] duty_e;
		logic [7:0] turn_on_duty_set2;
		logic [7:0] turn_off_duty_set2;
		logic [7:0] clamp_duty_set2;
		logic [1:0] duty_band_hysteresis;
		logic [7:0] turn_off_level_set1;
		logic [7:0] clamp_level_set1;
		logic [7:0] ref_a;
		logic [7:0] ref_b;
		logic [7:0] ref_c;
		logic [7:0] ref_d;
		logic [7:0] ref_e;
		logic [1:0] min_start_duty;
		srp_vmode_t vmode;
		logic filt_en;
		logic [7:0] turn_off_level_set2;
		logic [7:0] clamp_level_set2;
	} srp_cfg_t;
endpackage

// ==== srp_profile_cfg.sv ====
// Speed reference profile register bank with AXI4-Lite slave
// Overview of operation
// - Profile field codes 0-3 select direct, linear, staircase, forward-reverse.
// - First-set on, off and clamp duties are 8-bit codes over 256.
// - Duty A joins five high bits in word1 with word2 bits 30-28.
// - Duty E joins word2 bits 3-0 with word3 bits 30-27.
// - Duties B, C, D sit in word2 bits 27-20, 19-12, 11-4.
// - Second-set on, off, clamp sit in word3 bits 26-19, 18-11, 10-3.
// - Word3 bits 2-1 pick input duty hysteresis of 0 to 3 percent.
// - Word4 holds off level, clamp level and reference A.
// - Reference B joins word4 bits 6-0 with word5 bit 30.
// - References C, D, E sit in word5 bits 29-22, 21-14, 13-6.
// - Motor runs only once duty reaches the selected minimum start duty.
// - Mode 1 uses voltage mode above point C plus hysteresis.
// - Mode 0 never uses voltage mode; mode 2 reverses mode 1.
// - Filter bit set applies a 0.4 percent band to speed duty.
// - Word6 holds second off and clamp levels; bits 14-0 read zero.
// - All profile registers reset to zero.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`include "srp_profile_regs.svh"
module srp_profile_cfg
	import srp_profile_pkg::*;
#(
	parameter int ADDR_W = 12
)
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic [7:0] duty_i,
	output srp_cfg_t cfg_o,
	output logic [7:0] duty_filt_o,
	output logic run_o,
	output logic volt_mode_o
);

	// ==========================================================
	// State
	typedef struct packed {
		logic [5:0][31:0] word;
		logic aw_got;
		logic [ADDR_W-1:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic aw_rdy;
		logic w_rdy;
		logic b_vld;
		logic [1:0] b_resp;
		logic ar_rdy;
		logic r_vld;
		logic [31:0] r_data;
		logic [1:0] r_resp;
		logic [7:0] duty_f;
		logic run;
		logic volt;
	} srp_state_t;

	srp_state_t s_reg;
	srp_state_t s_next;

	// ==========================================================
	// Decoding helpers
	function automatic logic [2:0] slot_of(input logic [ADDR_W-1:0] a);
		logic [9:0] idx;
		idx = 10'(a >> 2);
		if (a[1:0] != 2'b00)
			slot_of = 3'd7;
		else if (idx == `SRP_IDX_WORD1)
			slot_of = 3'd0;
		else if (idx == `SRP_IDX_WORD2)
			slot_of = 3'd1;
		else if (idx == `SRP_IDX_WORD3)
			slot_of = 3'd2;
		else if (idx == `SRP_IDX_WORD4)
			slot_of = 3'd3;
		else if (idx == `SRP_IDX_WORD5)
			slot_of = 3'd4;
		else if (idx == `SRP_IDX_WORD6)
			slot_of = 3'd5;
		else if (idx == `SRP_IDX_STATUS)
			slot_of = 3'd6;
		else
			slot_of = 3'd7;
	endfunction

	function automatic logic [31:0] mask_of(input logic [2:0] sl);
		unique case (sl)
			3'd0: mask_of = `SRP_MASK_WORD1;
			3'd1: mask_of = `SRP_MASK_WORD2;
			3'd2: mask_of = `SRP_MASK_WORD3;
			3'd3: mask_of = `SRP_MASK_WORD4;
			3'd4: mask_of = `SRP_MASK_WORD5;
			3'd5: mask_of = `SRP_MASK_WORD6;
			default: mask_of = 32'h00000000;
		endcase
	endfunction

	function automatic logic [7:0] hys_code(input logic [1:0] c);
		unique case (c)
			2'd0: hys_code = `SRP_HYS_0;
			2'd1: hys_code = `SRP_HYS_1;
			2'd2: hys_code = `SRP_HYS_2;
			2'd3: hys_code = `SRP_HYS_3;
		endcase
	endfunction

	function automatic logic [7:0] min_code(input logic [1:0] c);
		unique case (c)
			2'd0: min_code = `SRP_MIN_0;
			2'd1: min_code = `SRP_MIN_1;
			2'd2: min_code = `SRP_MIN_2;
			2'd3: min_code = `SRP_MIN_3;
		endcase
	endfunction

	// ==========================================================
	// Field view of the register words
	always_comb
	begin
		cfg_o.profile = srp_prof_t'(s_reg.word[0][30:29]);
		cfg_o.turn_on_duty_set1 = s_reg.word[0][28:21];
		cfg_o.turn_off_duty_set1 = s_reg.word[0][20:13];
		cfg_o.clamp_duty_set1 = s_reg.word[0][12:5];
		// Upper bits from the lower-offset word
		cfg_o.duty_a = {s_reg.word[0][4:0], s_reg.word[1][30:28]};
		cfg_o.duty_b = s_reg.word[1][27:20];
		cfg_o.duty_c = s_reg.word[1][19:12];
		cfg_o.duty_d = s_reg.word[1][11:4];
		cfg_o.duty_e = {s_reg.word[1][3:0], s_reg.word[2][30:27]};
		cfg_o.turn_on_duty_set2 = s_reg.word[2][26:19];
		cfg_o.turn_off_duty_set2 = s_reg.word[2][18:11];
		cfg_o.clamp_duty_set2 = s_reg.word[2][10:3];
		cfg_o.duty_band_hysteresis = s_reg.word[2][2:1];
		cfg_o.turn_off_level_set1 = s_reg.word[3][30:23];
		cfg_o.clamp_level_set1 = s_reg.word[3][22:15];
		cfg_o.ref_a = s_reg.word[3][14:7];
		cfg_o.ref_b = {s_reg.word[3][6:0], s_reg.word[4][30]};
		cfg_o.ref_c = s_reg.word[4][29:22];
		cfg_o.ref_d = s_reg.word[4][21:14];
		cfg_o.ref_e = s_reg.word[4][13:6];
		cfg_o.min_start_duty = s_reg.word[4][5:4];
		cfg_o.vmode = srp_vmode_t'(s_reg.word[4][3:2]);
		cfg_o.filt_en = s_reg.word[4][1];
		cfg_o.turn_off_level_set2 = s_reg.word[5][30:23];
		cfg_o.clamp_level_set2 = s_reg.word[5][22:15];
	end

	assign s_axi_awready_o = s_reg.aw_rdy;
	assign s_axi_wready_o = s_reg.w_rdy;
	assign s_axi_bvalid_o = s_reg.b_vld;
	assign s_axi_bresp_o = s_reg.b_resp;
	assign s_axi_arready_o = s_reg.ar_rdy;
	assign s_axi_rvalid_o = s_reg.r_vld;
	assign s_axi_rdata_o = s_reg.r_data;
	assign s_axi_rresp_o = s_reg.r_resp;
	assign duty_filt_o = s_reg.duty_f;
	assign run_o = s_reg.run;
	assign volt_mode_o = s_reg.volt;

	// ==========================================================
	// Next state
	always_comb
	begin
		logic [2:0] ws;
		logic [2:0] rs;
		logic [31:0] m;
		logic [8:0] d9;
		logic [8:0] f9;
		logic [8:0] up;
		logic [8:0] c9;
		logic [8:0] h9;
		ws = 3'd7;
		rs = 3'd7;
		m = 32'h00000000;
		d9 = {1'b0, duty_i};
		f9 = {1'b0, s_reg.duty_f};
		c9 = {1'b0, cfg_o.duty_c};
		h9 = {1'b0, hys_code(cfg_o.duty_band_hysteresis)};
		up = c9 + h9;
		s_next = s_reg;
		// Write address and data, in either order
		if (s_reg.aw_rdy && s_axi_awvalid_i)
		begin
			s_next.aw_got = 1'b1;
			s_next.aw_addr = s_axi_awaddr_i;
		end
		if (s_reg.w_rdy && s_axi_wvalid_i)
		begin
			s_next.w_got = 1'b1;
			s_next.w_data = s_axi_wdata_i;
			s_next.w_strb = s_axi_wstrb_i;
		end
		if (s_reg.b_vld && s_axi_bready_i)
			s_next.b_vld = 1'b0;
		if (s_next.aw_got && s_next.w_got && !s_next.b_vld)
		begin
			ws = slot_of(s_next.aw_addr);
			for (int i = 0; i < 4; i++)
				m[i*8 +: 8] = {8{s_next.w_strb[i]}};
			// Parity and reserved bits are never written
			m = m & mask_of(ws);
			if (ws < 3'd6)
			begin
				s_next.word[ws] = (s_reg.word[ws] & ~m) |
					(s_next.w_data & m);
				s_next.b_resp = `SRP_RESP_OKAY;
			end
			else
				s_next.b_resp = `SRP_RESP_SLVERR;
			s_next.aw_got = 1'b0;
			s_next.w_got = 1'b0;
			s_next.b_vld = 1'b1;
		end
		s_next.aw_rdy = !s_next.aw_got && !s_next.b_vld;
		s_next.w_rdy = !s_next.w_got && !s_next.b_vld;
		// Read channel
		if (s_reg.r_vld && s_axi_rready_i)
			s_next.r_vld = 1'b0;
		if (s_reg.ar_rdy && s_axi_arvalid_i)
		begin
			rs = slot_of(s_axi_araddr_i);
			s_next.r_vld = 1'b1;
			s_next.r_resp = `SRP_RESP_OKAY;
			if (rs < 3'd6)
				s_next.r_data = s_reg.word[rs] & mask_of(rs);
			else if (rs == 3'd6)
				s_next.r_data = {22'h000000, s_reg.volt,
					s_reg.run, s_reg.duty_f};
			else
			begin
				s_next.r_data = 32'h00000000;
				s_next.r_resp = `SRP_RESP_SLVERR;
			end
		end
		s_next.ar_rdy = !s_next.r_vld;
		// Speed duty filter
		if (!cfg_o.filt_en)
			s_next.duty_f = duty_i;
		else if ((d9 > f9 + `SRP_FILT_BAND) ||
			(f9 > d9 + `SRP_FILT_BAND))
			s_next.duty_f = duty_i;
		// Start gate
		s_next.run = s_reg.duty_f >=
			min_code(cfg_o.min_start_duty);
		// Voltage mode split around point C
		unique case (cfg_o.vmode)
			SRP_VM_ABOVE:
			begin
				if (f9 > up)
					s_next.volt = 1'b1;
				else if (f9 + h9 < c9)
					s_next.volt = 1'b0;
			end
			SRP_VM_BELOW:
			begin
				if (f9 > up)
					s_next.volt = 1'b0;
				else if (f9 + h9 < c9)
					s_next.volt = 1'b1;
			end
			default:
				s_next.volt = 1'b0;
		endcase
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_wr_full(logic [9:0] idx);
		s_reg.aw_rdy && s_axi_awvalid_i && s_reg.w_rdy &&
		s_axi_wvalid_i && s_axi_wstrb_i == 4'hf &&
		s_axi_awaddr_i == ADDR_W'({idx, 2'b00});
	endsequence

	sequence s_rd_taken;
		s_reg.ar_rdy && s_axi_arvalid_i;
	endsequence

	property p_prof_write;
		s_wr_full(`SRP_IDX_WORD1) |=>
			cfg_o.profile == srp_prof_t'($past(s_axi_wdata_i[30:29]));
	endproperty
	a_prof_write: assert property (p_prof_write)
		else $error("profile field not taken from write");

	property p_duty_b_write;
		s_wr_full(`SRP_IDX_WORD2) |=>
			cfg_o.duty_b == $past(s_axi_wdata_i[27:20]) &&
			cfg_o.duty_a[2:0] == $past(s_axi_wdata_i[30:28]);
	endproperty
	a_duty_b_write: assert property (p_duty_b_write)
		else $error("duty word2 fields wrong");

	property p_ref_b_join;
		s_wr_full(`SRP_IDX_WORD5) |=>
			cfg_o.ref_b[0] == $past(s_axi_wdata_i[30]) &&
			cfg_o.ref_c == $past(s_axi_wdata_i[29:22]);
	endproperty
	a_ref_b_join: assert property (p_ref_b_join)
		else $error("reference B low bit wrong");

	property p_reserved_zero;
		s_rd_taken |=> s_axi_rdata_o[31] == 1'b0 &&
			s_reg.word[5][14:0] == 15'h0000 &&
			s_reg.word[2][0] == 1'b0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("parity or reserved bit not zero");

	property p_resp_pair;
		(s_reg.ar_rdy && s_axi_arvalid_i) ||
			(s_axi_rvalid_o && !s_axi_rready_i) |=> s_axi_rvalid_o;
	endproperty
	a_resp_pair: assert property (p_resp_pair)
		else $error("read answer dropped early");

	property p_run_gate;
		##1 run_o == ($past(s_reg.duty_f) >=
			min_code($past(cfg_o.min_start_duty)));
	endproperty
	a_run_gate: assert property (p_run_gate)
		else $error("run gate does not follow minimum duty");

	property p_vm_above;
		cfg_o.vmode == SRP_VM_ABOVE && {1'b0, s_reg.duty_f} >
			{1'b0, cfg_o.duty_c} +
			{1'b0, hys_code(cfg_o.duty_band_hysteresis)}
			|=> volt_mode_o;
	endproperty
	a_vm_above: assert property (p_vm_above)
		else $error("voltage mode not entered above point C");

	property p_vm_below;
		cfg_o.vmode == SRP_VM_BELOW && {1'b0, s_reg.duty_f} >
			{1'b0, cfg_o.duty_c} +
			{1'b0, hys_code(cfg_o.duty_band_hysteresis)}
			|=> !volt_mode_o;
	endproperty
	a_vm_below: assert property (p_vm_below)
		else $error("reversed split left voltage mode on");

	property p_vm_none;
		cfg_o.vmode == SRP_VM_NONE [*2] |-> !volt_mode_o;
	endproperty
	a_vm_none: assert property (p_vm_none)
		else $error("voltage mode used with split off");

	property p_filt_off;
		rst_n_i && !cfg_o.filt_en |=> duty_filt_o == $past(duty_i);
	endproperty
	a_filt_off: assert property (p_filt_off)
		else $error("unfiltered duty not passed through");

	property p_filt_hold;
		cfg_o.filt_en && (duty_i == s_reg.duty_f ||
			9'(duty_i) == 9'(s_reg.duty_f) + 9'h001 ||
			9'(duty_i) + 9'h001 == 9'(s_reg.duty_f)) |=> $stable(duty_filt_o);
	endproperty
	a_filt_hold: assert property (p_filt_hold)
		else $error("filter passed a change inside its band");

endmodule

// ==== srp_profile_cfg_test.sv ====
// Testbench for the speed reference profile register bank
`timescale 1ns/1ps
module srp_profile_cfg_test
	import srp_profile_pkg::*;
;
// ==========================================================
// Signals and tables
logic clk_i;
logic rst_n_i;
logic [11:0] awa, ara;
logic [31:0] wd, rdat, d;
logic [3:0] ws;
logic [1:0] bresp, rresp, resp;
logic awv, awr, wv, wr, bv, br, arv, arr, rv, rr, run, vm;
logic [7:0] duty, filt;
srp_cfg_t cfg;
int miscompares, compares, cyc;
logic [31:0] mk [6] = '{32'h7fffffff, 32'h7fffffff, 32'h7ffffffe,
	32'h7fffffff, 32'h7ffffffe, 32'h7fff8000};
logic [31:0] w [6] = '{32'h3c5a96e7, 32'h5b1e2d4c, 32'h6a3b5c7e,
	32'h2f4e6d8b, 32'h71a2b3cc, 32'h0f1e2d3c};
logic [7:0] mn [4] = '{8'h03, 8'h08, 8'h0d, 8'h1a};
logic [7:0] dq [6] = '{8'h7c, 8'h83, 8'h84, 8'h80, 8'h7d, 8'h7c};
logic [5:0] vx [4] = '{6'b000000, 6'b011100, 6'b100011, 6'b000000};
// ==========================================================
// Design
srp_profile_cfg srp_profile_cfg_i (
	.clk_i(clk_i),
	.rst_n_i(rst_n_i),
	.s_axi_awaddr_i(awa),
	.s_axi_awvalid_i(awv),
	.s_axi_awready_o(awr),
	.s_axi_wdata_i(wd),
	.s_axi_wstrb_i(ws),
	.s_axi_wvalid_i(wv),
	.s_axi_wready_o(wr),
	.s_axi_bresp_o(bresp),
	.s_axi_bvalid_o(bv),
	.s_axi_bready_i(br),
	.s_axi_araddr_i(ara),
	.s_axi_arvalid_i(arv),
	.s_axi_arready_o(arr),
	.s_axi_rdata_o(rdat),
	.s_axi_rresp_o(rresp),
	.s_axi_rvalid_o(rv),
	.s_axi_rready_i(rr),
	.duty_i(duty),
	.cfg_o(cfg),
	.duty_filt_o(filt),
	.run_o(run),
	.volt_mode_o(vm)
);
// ==========================================================
// Clock and timeout
initial
begin
	clk_i = 1'b0;
	forever #5 clk_i = ~clk_i;
end
always @(posedge clk_i)
begin
	cyc <= cyc + 1;
	if (cyc == 8000)
	begin
		miscompares++;
		final_report();
	end
end
// ==========================================================
// Tasks
function automatic logic [11:0] adr(input int i);
	return 12'h250 + 12'(8 * i);
endfunction
task automatic chk(input string n, input logic [31:0] x,
	input logic [31:0] g);
	compares++;
	if (g !== x)
	begin
		miscompares++;
		$display("[ERR] %s exp %h got %h", n, x, g);
	end
endtask
task automatic wr_reg(input logic [11:0] a, input logic [31:0] v);
	@(posedge clk_i);
	awa <= a;
	wd <= v;
	ws <= 4'hf;
	awv <= 1'b1;
	wv <= 1'b1;
	br <= 1'b1;
	do
	begin
		@(posedge clk_i);
		if (awv && awr)
			awv <= 1'b0;
		if (wv && wr)
			wv <= 1'b0;
	end
	while (!(br && bv));
	resp = bresp;
	br <= 1'b0;
endtask
task automatic rd_reg(input logic [11:0] a);
	@(posedge clk_i);
	ara <= a;
	arv <= 1'b1;
	rr <= 1'b1;
	do
	begin
		@(posedge clk_i);
		if (arv && arr)
			arv <= 1'b0;
	end
	while (!(rr && rv));
	d = rdat;
	resp = rresp;
	rr <= 1'b0;
endtask
task automatic set_duty(input logic [7:0] v);
	@(posedge clk_i);
	duty <= v;
	repeat (3) @(posedge clk_i);
endtask
task automatic final_report();
	if (miscompares == 0 && compares > 0)
		$display("ALL CHECKS OK");
	else
		$display("CHECKS NOT OK");
	$finish;
endtask
// ==========================================================
// Sequence
initial
begin
	rst_n_i = 1'b0;
	{awa, ara, wd, ws, awv, wv, br, arv, rr, duty} = '0;
	repeat (6) @(posedge clk_i);
	rst_n_i <= 1'b1;
	chk("reset cfg", 32'h0, 32'(cfg != '0));
	for (int i = 0; i < 6; i++)
	begin
		rd_reg(adr(i));
		chk("reset word", 32'h0, d);
		wr_reg(adr(i), 32'hffffffff);
		rd_reg(adr(i));
		chk("mask word", mk[i], d);
		chk("rd resp", 32'h0, 32'(resp));
	end
	wr_reg(12'h284, 32'hffffffff);
	chk("bad wr resp", 32'h2, 32'(resp));
	rd_reg(12'h252);
	chk("bad rd resp", 32'h2, 32'(resp));
	chk("bad rd data", 32'h0, d);
	for (int i = 0; i < 6; i++)
		wr_reg(adr(i), w[i]);
	chk("set1 duty", 32'(w[0][28:5]), 32'({cfg.turn_on_duty_set1,
		cfg.turn_off_duty_set1, cfg.clamp_duty_set1}));
	chk("wr resp", 32'h0, 32'(resp));
	chk("duty a", 32'({w[0][4:0], w[1][30:28]}),
		32'(cfg.duty_a));
	chk("duty bcd", 32'(w[1][27:4]),
		32'({cfg.duty_b, cfg.duty_c, cfg.duty_d}));
	chk("duty e", 32'({w[1][3:0], w[2][30:27]}),
		32'(cfg.duty_e));
	chk("set2 duty", 32'(w[2][26:3]), 32'({cfg.turn_on_duty_set2,
		cfg.turn_off_duty_set2, cfg.clamp_duty_set2}));
	chk("hys", 32'(w[2][2:1]), 32'(cfg.duty_band_hysteresis));
	chk("levels1", 32'(w[3][30:7]), 32'({cfg.turn_off_level_set1,
		cfg.clamp_level_set1, cfg.ref_a}));
	chk("ref b", 32'({w[3][6:0], w[4][30]}),
		32'(cfg.ref_b));
	chk("ref cde", 32'(w[4][29:6]),
		32'({cfg.ref_c, cfg.ref_d, cfg.ref_e}));
	chk("mode bits", 32'(w[4][5:1]),
		32'({cfg.min_start_duty, cfg.vmode, cfg.filt_en}));
	chk("levels2", 32'(w[5][30:15]),
		32'({cfg.turn_off_level_set2, cfg.clamp_level_set2}));
	for (int c = 0; c < 4; c++)
	begin
		wr_reg(adr(0), 32'(c) << 29);
		chk("profile", 32'(c), 32'(cfg.profile));
	end
	for (int m = 0; m < 4; m++)
	begin
		wr_reg(adr(4), 32'(m) << 4);
		set_duty(mn[m] - 8'h01);
		chk("run low", 32'h0, 32'(run));
		set_duty(mn[m]);
		chk("run high", 32'h1, 32'(run));
	end
	wr_reg(adr(1), 32'h00080000);
	wr_reg(adr(2), 32'h00000002);
	for (int v = 0; v < 4; v++)
	begin
		wr_reg(adr(4), 32'(v) << 2);
		for (int j = 0; j < 6; j++)
		begin
			set_duty(dq[j]);
			chk("volt mode", 32'(vx[v][j]), 32'(vm));
		end
	end
	wr_reg(adr(4), 32'h00000002);
	set_duty(8'h7d);
	chk("filt small", 32'h7c, 32'(filt));
	set_duty(8'h7e);
	chk("filt step", 32'h7e, 32'(filt));
	set_duty(8'h7d);
	chk("filt hold", 32'h7e, 32'(filt));
	wr_reg(adr(4), 32'h00000000);
	set_duty(8'h7d);
	chk("filt off", 32'h7d, 32'(filt));
	rd_reg(12'h280);
	chk("status rd", 32'h0000017d, d);
	chk("status resp", 32'h0, 32'(resp));
	wr_reg(12'h280, 32'hffffffff);
	chk("status wr resp", 32'h2, 32'(resp));
	// Reset in mid-run clears every written word
	@(posedge clk_i);
	rst_n_i <= 1'b0;
	repeat (2) @(posedge clk_i);
	rst_n_i <= 1'b1;
	chk("rerun cfg", 32'h0, 32'(cfg != '0));
	for (int i = 0; i < 6; i++)
	begin
		rd_reg(adr(i));
		chk("rerun word", 32'h0, d);
	end
	final_report();
end
endmodule
